//--- rtl/pbws_top.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pbws_consts.svh"
// Notes on behaviour
// - Soft-off plus short press under four seconds goes to working.
// - Working plus short press under four seconds goes to sleeping.
// - Working or sleeping, held over six seconds, forces soft-off.
// - Sleeping plus short press under four seconds wakes to working.
// - States S0, S1, S3, S4 and S5 are supported.
// - In S3, S4, S5 device power is removed; wake logic stays on.
// - Switch, RTC, WAKE, network and PME wake from S1 to S5.
// - USB wakes only from S1/S3; infrared from S4/S5 optionally.
// - Network and PME wake from S5 off by default until enabled.
// - Closed intrusion switch reports chassis intrusion.
// - Five rails monitored; out-of-window rails flagged.
// - Closed-loop thermal control for all eight fans.
// - Fans run in S0 and S1, off elsewhere.
// - PME wakes only when wake-on-PME is enabled.
module pbws_top #(
  parameter int unsigned SHORT_CYC = `PBWS_SHORT_MS * 1000 * `PBWS_CLK_MHZ,
  parameter int unsigned LONG_CYC = `PBWS_LONG_MS * 1000 * `PBWS_CLK_MHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwr_switch,
  input wire logic wake_rtc,
  input wire logic wake_pcie,
  input wire logic wake_lan,
  input wire logic wake_pme,
  input wire logic wake_usb,
  input wire logic wake_cir,
  input wire logic intrusion_closed,
  input wire logic [4:0] rail_high,
  input wire logic [4:0] rail_low,
  input wire logic [7:0] temp,
  output logic dev_power_on,
  output logic cpu_run,
  output logic [7:0] fan_pwm,
  output logic irq
);
  import pbws_pkg::*;

  pbws_state_t state_q;
  logic [31:0] hold_q;
  logic btn_q;
  logic [3:0] wcfg_q;
  logic [3:0] stat_q;
  logic [3:0] ien_q;
  logic [7:0] fant_q;
  logic [2:0] slp_req_q;
  logic slp_go_q;
  logic intr_q;
  logic [4:0] rail_q;
  logic [7:0] pwm_cnt_q;
  logic [2:0] fan_idx_q;
  logic [2:0] fan_wr_idx_q;
  logic fan_we_q;
  logic [7:0] fan_wd_q;
  logic [7:0] fan_rd;
  logic [2:0] fan_rd_idx_q;
  logic [2:0] fan_pwm_idx_q;
  logic [7:0] duty_q;
  logic wake_ev;
  logic state_ev;
  logic release_ev;
  logic wr;
  logic rd;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_sleep(input pbws_state_t s);
    is_sleep = (s == PBWS_S1) || (s == PBWS_S3) || (s == PBWS_S4);
  endfunction

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign release_ev = btn_q & ~pwr_switch;

  // ****************************************
  // Wake qualification
  // ****************************************
  always_comb begin
    wake_ev = 1'b0;
    if (state_q != PBWS_S0) begin
      wake_ev = wake_rtc | wake_pcie;
      if (state_q != PBWS_S5) begin
        wake_ev = wake_ev | wake_lan;
        wake_ev = wake_ev | (wake_pme & wcfg_q[`PBWS_WCFG_PME_EN]);
      end else begin
        wake_ev = wake_ev | (wake_lan & wcfg_q[`PBWS_WCFG_LAN_S5]);
        wake_ev = wake_ev | (wake_pme & wcfg_q[`PBWS_WCFG_PME_EN] & wcfg_q[`PBWS_WCFG_PME_S5]);
      end
      if (state_q == PBWS_S1 || state_q == PBWS_S3) begin
        wake_ev = wake_ev | wake_usb | wake_cir;
      end else begin
        wake_ev = wake_ev | (wake_cir & wcfg_q[`PBWS_WCFG_CIR_S45]);
      end
    end
  end

  // ****************************************
  // Power switch timing
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      btn_q <= 1'b0;
      hold_q <= 32'h0000_0000;
    end else begin
      btn_q <= pwr_switch;
      if (!pwr_switch) begin
        hold_q <= 32'h0000_0000;
      end else if (hold_q != 32'hFFFF_FFFF) begin
        hold_q <= hold_q + 32'h0000_0001;
      end
    end
  end

  // Sleep request latch from software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slp_req_q <= 3'h0;
      slp_go_q <= 1'b0;
    end else begin
      slp_go_q <= wr && is_addr(paddr, `PBWS_OFF_CMD);
      if (wr && is_addr(paddr, `PBWS_OFF_CMD)) begin
        slp_req_q <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= PBWS_S5;
      state_ev <= 1'b0;
    end else begin
      state_ev <= 1'b0;
      case (state_q)
        PBWS_S0: begin
          if (pwr_switch && hold_q >= LONG_CYC) begin
            state_q <= PBWS_S5;
            state_ev <= 1'b1;
          end else if (release_ev && hold_q < SHORT_CYC) begin
            state_q <= PBWS_S1;
            state_ev <= 1'b1;
          end else if (slp_go_q) begin
            // Software-directed sleep depth
            case (slp_req_q)
              3'h1: state_q <= PBWS_S1;
              3'h3: state_q <= PBWS_S3;
              3'h4: state_q <= PBWS_S4;
              3'h5: state_q <= PBWS_S5;
              default: state_q <= PBWS_S0;
            endcase
            // Only a valid depth code counts as a change
            state_ev <= (slp_req_q == 3'h1) || (slp_req_q == 3'h3) || (slp_req_q == 3'h4) || (slp_req_q == 3'h5);
          end
          // Release between the two windows is ignored
        end
        PBWS_S1, PBWS_S3, PBWS_S4: begin
          if (pwr_switch && hold_q >= LONG_CYC) begin
            state_q <= PBWS_S5;
            state_ev <= 1'b1;
          end else if ((release_ev && hold_q < SHORT_CYC) || wake_ev) begin
            state_q <= PBWS_S0;
            state_ev <= 1'b1;
          end
        end
        PBWS_S5: begin
          if ((release_ev && hold_q < SHORT_CYC) || wake_ev) begin
            state_q <= PBWS_S0;
            state_ev <= 1'b1;
          end
        end
        default: state_q <= PBWS_S5;
      endcase
    end
  end

  // ****************************************
  // Power outputs
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_power_on <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      dev_power_on <= (state_q == PBWS_S0) || (state_q == PBWS_S1);
      cpu_run <= (state_q == PBWS_S0);
    end
  end

  // ****************************************
  // Monitors
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intr_q <= 1'b0;
      rail_q <= 5'h00;
    end else begin
      intr_q <= intrusion_closed;
      rail_q <= rail_high | rail_low;
    end
  end

  // ****************************************
  // Fan control, eight fans round-robin
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fan_idx_q <= 3'h0;
      fan_rd_idx_q <= 3'h0;
      fan_pwm_idx_q <= 3'h0;
      fan_wr_idx_q <= 3'h0;
      fan_we_q <= 1'b0;
      fan_wd_q <= 8'h00;
      duty_q <= 8'h00;
    end else begin
      fan_idx_q <= fan_idx_q + 3'h1;
      fan_rd_idx_q <= fan_idx_q;
      // Index follows the duty through the memory and duty stages
      fan_pwm_idx_q <= fan_rd_idx_q;
      fan_wr_idx_q <= fan_idx_q;
      fan_we_q <= 1'b1;
      // Proportional duty above threshold
      if (temp > fant_q) begin
        fan_wd_q <= ((temp - fant_q) > 8'h3F) ? `PBWS_PWM_STEPS : 8'((temp - fant_q) << 2);
      end else begin
        fan_wd_q <= 8'h00;
      end
      duty_q <= fan_rd;
    end
  end

  pbws_fan_mem u_fan_mem (
    .clk(clk),
    .we(fan_we_q),
    .waddr(fan_wr_idx_q),
    .wdata(fan_wd_q),
    .raddr(fan_idx_q),
    .rdata(fan_rd)
  );

  // PWM generation per fan
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt_q <= 8'h00;
      fan_pwm <= 8'h00;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (!((state_q == PBWS_S0) || (state_q == PBWS_S1))) begin
        fan_pwm <= 8'h00;
      end else begin
        fan_pwm[fan_pwm_idx_q] <= (duty_q > pwm_cnt_q);
      end
    end
  end

  // ****************************************
  // Interrupt status, enable and clear
  // ****************************************
  // Sticky status, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~((wr && is_addr(paddr, `PBWS_OFF_ICLR)) ? pwdata[3:0] : 4'h0))
                | {|rail_q, intr_q, wake_ev, state_ev};
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ien_q <= 4'h0;
    end else begin
      if (wr && is_addr(paddr, `PBWS_OFF_IEN)) begin
        ien_q <= pwdata[3:0];
      end
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & ien_q);
    end
  end

  // ****************************************
  // APB config registers and read data
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wcfg_q <= `PBWS_WCFG_RST;
      fant_q <= `PBWS_FANT_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (wr && is_addr(paddr, `PBWS_OFF_WCFG)) begin
        wcfg_q <= pwdata[3:0];
      end
      if (wr && is_addr(paddr, `PBWS_OFF_FANT)) begin
        fant_q <= pwdata[7:0];
      end
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `PBWS_OFF_STATE: prdata <= {29'h0000_0000, state_q};
          `PBWS_OFF_CMD: prdata <= {29'h0000_0000, slp_req_q};
          `PBWS_OFF_WCFG: prdata <= {28'h000_0000, wcfg_q};
          `PBWS_OFF_MON: prdata <= {26'h000_0000, rail_q, intr_q};
          `PBWS_OFF_STAT: prdata <= {28'h000_0000, stat_q};
          `PBWS_OFF_IEN: prdata <= {28'h000_0000, ien_q};
          `PBWS_OFF_ICLR: prdata <= 32'h0000_0000;
          `PBWS_OFF_FANT: prdata <= {24'h00_0000, fant_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd;
endmodule
`default_nettype wire

//--- rtl/pbws_consts.svh
`ifndef PBWS_CONSTS_SVH
`define PBWS_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PBWS_OFF_STATE 12'h000
`define PBWS_OFF_CMD 12'h004
`define PBWS_OFF_WCFG 12'h008
`define PBWS_OFF_MON 12'h00C
`define PBWS_OFF_STAT 12'h010
`define PBWS_OFF_IEN 12'h014
`define PBWS_OFF_ICLR 12'h018
`define PBWS_OFF_FANT 12'h01C
// ****************************************
// Field positions
// ****************************************
`define PBWS_WCFG_LAN_S5 0
`define PBWS_WCFG_PME_S5 1
`define PBWS_WCFG_PME_EN 2
`define PBWS_WCFG_CIR_S45 3
`define PBWS_EV_STATE 0
`define PBWS_EV_WAKE 1
`define PBWS_EV_INTR 2
`define PBWS_EV_RAIL 3
// ****************************************
// Reset values and timing
// ****************************************
`define PBWS_WCFG_RST 4'h0
`define PBWS_FANT_RST 8'h50
`define PBWS_CLK_MHZ 250
`define PBWS_SHORT_MS 4000
`define PBWS_LONG_MS 6000
`define PBWS_PWM_STEPS 8'hFF
`endif

//--- rtl/pbws_pkg.sv
package pbws_pkg;
  typedef enum logic [2:0] {
    PBWS_S0,
    PBWS_S1,
    PBWS_S3,
    PBWS_S4,
    PBWS_S5
  } pbws_state_t;
endpackage

//--- rtl/pbws_fan_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Per-fan duty memory, registered read
// ****************************************
module pbws_fan_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [0:7];

  // Write port and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule
`default_nettype wire

//--- tb/pbws_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Sequencer checker
// ****
module pbws_sva #(
  parameter int unsigned SHORT_CYC = 40,
  parameter int unsigned LONG_CYC = 60
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pwr_switch,
  input wire logic wake_rtc,
  input wire logic dev_power_on,
  input wire logic cpu_run,
  input wire logic [7:0] fan_pwm
);
  int unsigned hold_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Cycles the switch has been held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hold_q <= 0;
    else hold_q <= pwr_switch ? hold_q + 1 : 0;
  end
  sequence short_rel;
    $fell(pwr_switch) && hold_q < SHORT_CYC;
  endsequence
  sequence mid_rel;
    $fell(pwr_switch) && hold_q > SHORT_CYC + 2 && hold_q < LONG_CYC - 2;
  endsequence
  chk_short_on: assert property (!dev_power_on ##0 short_rel |-> ##[1:8] cpu_run)
    else $error("short press did not power on");
  chk_short_sleep: assert property (cpu_run ##0 short_rel |-> ##[1:8] (dev_power_on && !cpu_run))
    else $error("short press did not enter sleep");
  chk_short_resume: assert property ((dev_power_on && !cpu_run) ##0 short_rel |-> ##[1:8] cpu_run)
    else $error("short press did not resume");
  chk_mid_hold: assert property (cpu_run ##0 mid_rel |-> cpu_run [*8])
    else $error("mid length press changed state");
  chk_long_off: assert property (dev_power_on && hold_q == LONG_CYC |-> ##[0:4] !dev_power_on)
    else $error("long press did not force off");
  chk_run_pwr: assert property (cpu_run |-> dev_power_on)
    else $error("processor runs without power");
  chk_fan_off: assert property (!dev_power_on [*2] |-> fan_pwm == 8'h00)
    else $error("fans run while off");
  chk_rtc_wake: assert property (wake_rtc && !dev_power_on |-> ##[1:8] dev_power_on)
    else $error("alarm did not wake");
endmodule
`default_nettype wire

//--- tb/pbws_far.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Switch and wake sources
// ****
module pbws_far (
  input wire logic clk,
  output logic pwr_switch,
  output logic wake_rtc,
  output logic wake_pcie,
  output logic wake_lan,
  output logic wake_pme,
  output logic wake_usb,
  output logic wake_cir
);
  logic [5:0] w = 6'h00;
  initial pwr_switch = 1'b0;
  // Released wake lines read low
  assign {wake_cir, wake_usb, wake_pme, wake_lan, wake_pcie, wake_rtc} = w;
  task automatic press(input int n);
    @(posedge clk);
    pwr_switch <= 1'b1;
    repeat (n) @(posedge clk);
    pwr_switch <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  task automatic wake(input logic [3:0] i);
    repeat (4) @(posedge clk);
    w[i] <= 1'b1;
    repeat (6) @(posedge clk);
    w <= 6'h00;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbws_consts.svh"
// ****
// Testbench
// ****
module tb_top;
  localparam int unsigned SHORT_CYC = 40;
  localparam int unsigned LONG_CYC = 60;
  localparam logic [15:0] TBL [12] = '{16'h3400, 16'h4403, 16'h4000, 16'h5100, 16'h5204, 16'h5210,
    16'h1301, 16'h1340, 16'h5344, 16'h5360, 16'h5504, 16'h5580};
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pwr_switch, wake_rtc, wake_pcie, wake_lan, wake_pme, wake_usb, wake_cir;
  logic intrusion_closed = 1'b0;
  logic [4:0] rail_high = 5'h00, rail_low = 5'h00;
  logic [7:0] temp = 8'h00, fan_pwm;
  logic dev_power_on, cpu_run, irq;
  int n_errors = 0, n_checks = 0, cyc = 0;
  pbws_top #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) pbws_top_inst (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwr_switch, .wake_rtc, .wake_pcie, .wake_lan,
    .wake_pme, .wake_usb, .wake_cir, .intrusion_closed, .rail_high, .rail_low, .temp, .dev_power_on,
    .cpu_run, .fan_pwm, .irq);
  pbws_far pbws_far_inst (.clk, .pwr_switch, .wake_rtc, .wake_pcie, .wake_lan, .wake_pme, .wake_usb,
    .wake_cir);
  always #2 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic t_press;
    pbws_far_inst.press(10);
    rd(`PBWS_OFF_STATE, 32'h0);
    pbws_far_inst.press(10);
    rd(`PBWS_OFF_STATE, 32'h1);
    pbws_far_inst.press(10);
    rd(`PBWS_OFF_STATE, 32'h0);
    pbws_far_inst.press(50);
    rd(`PBWS_OFF_STATE, 32'h0);
    pbws_far_inst.press(70);
    rd(`PBWS_OFF_STATE, 32'h4);
    $display("t_press done");
  endtask
  task automatic t_fan;
    int cnt;
    pbws_far_inst.press(10);
    temp <= 8'h60;
    repeat (24) @(posedge clk);
    cnt = 0;
    repeat (255) @(posedge clk) cnt += fan_pwm[0];
    chk({31'h0, cnt inside {[60:68]}}, 32'h1);
    temp <= 8'h40;
    repeat (24) @(posedge clk);
    chk({24'h0, fan_pwm}, 32'h0);
    temp <= 8'hFF;
    $display("t_fan done");
  endtask
  task automatic t_wake;
    logic [15:0] e;
    foreach (TBL[i]) begin
      e = TBL[i];
      wr(`PBWS_OFF_WCFG, {28'h0, e[7:4]});
      if (cpu_run !== 1'b1) pbws_far_inst.press(10);
      wr(`PBWS_OFF_CMD, {28'h0, e[15:12]});
      pbws_far_inst.wake(e[11:8]);
      rd(`PBWS_OFF_STATE, {28'h0, e[3:0]});
      chk({30'h0, dev_power_on, cpu_run}, e[3:0] == 0 ? 3 : e[3:0] == 1 ? 2 : 0);
    end
    $display("t_wake done");
  endtask
  task automatic t_mon;
    logic [31:0] r;
    logic e;
    wr(`PBWS_OFF_IEN, 32'h0);
    intrusion_closed <= 1'b1;
    rail_high <= 5'h04;
    rail_low <= 5'h01;
    wr(`PBWS_OFF_ICLR, 32'hF);
    rd(`PBWS_OFF_MON, 32'hB);
    rd(`PBWS_OFF_STAT, 32'hC);
    chk({31'h0, irq}, 32'h0);
    wr(`PBWS_OFF_IEN, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    intrusion_closed <= 1'b0;
    rail_high <= 5'h00;
    rail_low <= 5'h00;
    wr(`PBWS_OFF_ICLR, 32'hC);
    rd(`PBWS_OFF_STAT, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("t_mon done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(`PBWS_OFF_STATE, 32'h4);
    rd(`PBWS_OFF_WCFG, {28'h0, `PBWS_WCFG_RST});
    rd(`PBWS_OFF_FANT, {24'h0, `PBWS_FANT_RST});
    t_press();
    t_fan();
    t_wake();
    t_mon();
    complete_run();
  end
endmodule
bind pbws_top pbws_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) pbws_sva_inst (.clk(clk), .resetn(resetn),
  .pwr_switch(pwr_switch), .wake_rtc(wake_rtc), .dev_power_on(dev_power_on), .cpu_run(cpu_run), .fan_pwm(fan_pwm));
`default_nettype wire
